//--- src/fndc_regs.vh
`ifndef FNDC_REGS_VH
`define FNDC_REGS_VH

// Register address field, bits 1:0 of each 24-bit word
`define FNDC_ADDR_NDIV   2'h0
`define FNDC_ADDR_RDIV   2'h1
`define FNDC_ADDR_CTRL   2'h2
`define FNDC_ADDR_NOISE  2'h3

// N-divider word fields
`define FNDC_N_FAST_BIT  23
`define FNDC_N_INT_HI    22
`define FNDC_N_INT_LO    14
`define FNDC_N_NUM_HI    13
`define FNDC_N_NUM_LO    2

// R-divider word fields
`define FNDC_R_LOAD_BIT  23
`define FNDC_R_MON_HI    22
`define FNDC_R_MON_LO    20
`define FNDC_R_RDIV_HI   19
`define FNDC_R_RDIV_LO   16
`define FNDC_R_DEN_HI    13
`define FNDC_R_DEN_LO    2

// Control word fields
`define FNDC_C_CP_HI     10
`define FNDC_C_CP_LO     7
`define FNDC_C_DBL_BIT   11

// Noise and spur word fields, lowest-spur code
`define FNDC_S_MODE_HI   10
`define FNDC_S_MODE_LO   2
`define FNDC_S_LOWSPUR   9'h1C7

// Monitor select code for the fast-lock switch
`define FNDC_MON_FASTLOCK 3'h6

// Reset values
`define FNDC_RST_DEN     12'h002
`define FNDC_RST_RDIV    4'h1
`define FNDC_RST_INT     9'h01F

// Charge pump boost during wide bandwidth
`define FNDC_CP_BOOST_SH 4

// Dither LFSR repeat length exponent
`define FNDC_DITHER_BITS 21

`endif

//--- src/fndc_ref_div.v
`timescale 1ns/100ps
`default_nettype none

// Comparator-rate enable from reference edges, doubler and divide factor
module fndc_ref_div (
    input  wire        core_clk,  // Core clock
    input  wire        resetn,    // Async reset, active low
    input  wire        ref_in,    // Reference input pin, asynchronous
    input  wire        doubler,   // Count both edges when set
    input  wire [3:0]  rdiv,      // Divide factor, 1 to 15
    output reg         cmp_tick   // One-cycle comparator-rate enable
);

    reg        sync1_r;
    reg        sync2_r;
    reg        prev_r;
    reg  [3:0] cnt_r;
    wire       rise;
    wire       fall;
    wire       edge_hit;

    // Two-stage synchroniser for the reference pin
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            prev_r  <= 1'b0;
        end else begin
            sync1_r <= ref_in;
            sync2_r <= sync1_r;
            prev_r  <= sync2_r;
        end
    end

    assign rise     = sync2_r & ~prev_r;
    assign fall     = ~sync2_r & prev_r;
    assign edge_hit = fall | (doubler & rise);

    // Divide active edges by the reference factor
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_r    <= 4'h0;
            cmp_tick <= 1'b0;
        end else begin
            cmp_tick <= 1'b0;
            if (edge_hit) begin
                if (cnt_r + 4'h1 >= ((rdiv == 4'h0) ? 4'h1 : rdiv)) begin
                    cnt_r    <= 4'h0;
                    cmp_tick <= 1'b1;
                end else begin
                    cnt_r <= cnt_r + 4'h1;
                end
            end
        end
    end

endmodule // fndc_ref_div

`default_nettype wire

//--- src/fndc_core.v
// How it works
// - Divide ratio is whole value plus numerator over denominator each comparator cycle.
// - Comparator rate is reference times one-plus-doubler, divided by reference factor.
// - Denominator accepted from 2 to 4095 in a 12-bit field.
// - Third-order interpolator steps once per comparator cycle.
// - Without dither the sequence repeats per denominator factors of two and three.
// - With dither the repeat length is two to the twenty-first cycles.
// - Load-select bit 23 set stores bits 13:2 as fast-lock timer value.
// - Wide bandwidth lasts timer-value comparator cycles.
// - Monitor select 110 makes the monitor pin the fast-lock switch to ground.
// - N-divider write with bit 23 set starts fast lock.
// - Charge pump current is sixteen times programmed value in wide bandwidth.
// - New denominator takes effect only after the next N-divider write.
// - Lowest-spur setting enables dither; other settings disable it.
`timescale 1ns/100ps
`default_nettype none
`include "fndc_regs.vh"

module fndc_core (
    input  wire        core_clk,        // Core clock, 250 MHz
    input  wire        resetn,          // Async reset, active low
    input  wire        reference_input, // Reference pin, asynchronous
    input  wire        wr_stb,          // One-cycle strobe, latched word valid
    input  wire [23:0] wr_word,         // Latched 24-bit word, bits 1:0 address
    output wire        cmp_tick,        // Comparator-rate enable pulse
    output reg  [12:0] div_ratio,       // Per-cycle divide value to counters
    output reg  [8:0]  int_value,       // Active whole divide value
    output reg  [11:0] numerator_value, // Active numerator
    output reg  [11:0] denominator_value, // Active denominator
    output reg         dither_on,       // Dither enabled
    output reg  [3:0]  cp_setting,      // Programmed charge pump code
    output reg  [8:0]  cp_current,      // Effective pump current, code units
    output reg         wide_bw,         // Wide-bandwidth mode active
    output reg         monitor_output_pin_oe_n, // Low while pulling pin to ground
    output wire        monitor_output_pin_out   // Pin level when driven
);

    reg  [11:0] den_pend_r;
    reg  [11:0] timer_val_r;
    reg  [11:0] timer_cnt_r;
    reg  [2:0]  mon_sel_r;
    reg  [3:0]  rdiv_r;
    reg         dbl_r;
    reg  [11:0] acc1_r;
    reg  [11:0] acc2_r;
    reg  [11:0] acc3_r;
    reg  [1:0]  c2_d_r;
    reg         c3_d_r;
    reg         c3_dd_r;
    reg  [20:0] lfsr_r;
    reg         fl_start_r;

    wire [1:0]  waddr = wr_word[1:0];
    wire [11:0] wfield = wr_word[`FNDC_R_DEN_HI:`FNDC_R_DEN_LO];

    // Modulo add for one accumulator stage, returns carry in bit 12
    function [12:0] mod_add;
        input [11:0] a;
        input [11:0] b;
        input [11:0] m;
        reg   [12:0] s;
        begin
            s = {1'b0, a} + {1'b0, b};
            if (s >= {1'b0, m})
                mod_add = {1'b1, s[11:0] - m};
            else
                mod_add = {1'b0, s[11:0]};
        end
    endfunction

    fndc_ref_div u_ref_div (
        .core_clk (core_clk),
        .resetn   (resetn),
        .ref_in   (reference_input),
        .doubler  (dbl_r),
        .rdiv     (rdiv_r),
        .cmp_tick (cmp_tick)
    );

    assign monitor_output_pin_out = 1'b0;

    // Register word decode
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            den_pend_r        <= `FNDC_RST_DEN;
            denominator_value <= `FNDC_RST_DEN;
            timer_val_r       <= 12'h000;
            mon_sel_r         <= 3'h0;
            rdiv_r            <= `FNDC_RST_RDIV;
            dbl_r             <= 1'b0;
            cp_setting        <= 4'h0;
            dither_on         <= 1'b0;
            int_value         <= `FNDC_RST_INT;
            numerator_value   <= 12'h000;
            fl_start_r        <= 1'b0;
        end else begin
            if (cmp_tick)
                fl_start_r <= 1'b0;
            if (wr_stb) begin
                case (waddr)
                    `FNDC_ADDR_RDIV: begin
                        if (wr_word[`FNDC_R_LOAD_BIT]) begin
                            timer_val_r <= wfield;
                        end else begin
                            mon_sel_r  <= wr_word[`FNDC_R_MON_HI:`FNDC_R_MON_LO];
                            rdiv_r     <= wr_word[`FNDC_R_RDIV_HI:`FNDC_R_RDIV_LO];
                            // Values below 2 clamp to 2
                            den_pend_r <= (wfield < 12'h002) ? 12'h002 : wfield;
                        end
                    end
                    `FNDC_ADDR_CTRL: begin
                        cp_setting <= wr_word[`FNDC_C_CP_HI:`FNDC_C_CP_LO];
                        dbl_r      <= wr_word[`FNDC_C_DBL_BIT];
                    end
                    `FNDC_ADDR_NOISE: begin
                        dither_on <= (wr_word[`FNDC_S_MODE_HI:`FNDC_S_MODE_LO]
                                      == `FNDC_S_LOWSPUR);
                    end
                    default: begin
                        int_value         <= wr_word[`FNDC_N_INT_HI:`FNDC_N_INT_LO];
                        numerator_value   <= wr_word[`FNDC_N_NUM_HI:`FNDC_N_NUM_LO];
                        denominator_value <= den_pend_r;
                        if (wr_word[`FNDC_N_FAST_BIT])
                            fl_start_r <= 1'b1;
                    end
                endcase
            end
        end
    end

    // Fast-lock timer, counted in comparator cycles
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            timer_cnt_r <= 12'h000;
            wide_bw     <= 1'b0;
        end else if (cmp_tick) begin
            if (fl_start_r && timer_val_r != 12'h000) begin
                timer_cnt_r <= timer_val_r;
                wide_bw     <= 1'b1;
            end else if (timer_cnt_r > 12'h001) begin
                timer_cnt_r <= timer_cnt_r - 12'h001;
            end else begin
                timer_cnt_r <= 12'h000;
                wide_bw     <= 1'b0;
            end
        end
    end

    // Pump boost and monitor switch
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cp_current              <= 9'h000;
            monitor_output_pin_oe_n <= 1'b1;
        end else begin
            cp_current <= wide_bw ? ({5'h00, cp_setting} << `FNDC_CP_BOOST_SH)
                                  : {5'h00, cp_setting};
            monitor_output_pin_oe_n <= ~(wide_bw &&
                                         mon_sel_r == `FNDC_MON_FASTLOCK);
        end
    end

    // Third-order cascaded accumulators with dither on the first input
    reg  [12:0] s1;
    reg  [12:0] s2;
    reg  [12:0] s3;
    reg  [11:0] numerator_value_in;
    reg  signed [4:0] corr;
    reg  [12:0] ratio_sum;
    always @* begin
        numerator_value_in = numerator_value;
        if (dither_on && lfsr_r[0] && numerator_value < denominator_value - 12'h001)
            numerator_value_in = numerator_value + 12'h001;
        s1 = mod_add(acc1_r, numerator_value_in, denominator_value);
        s2 = mod_add(acc2_r, s1[11:0], denominator_value);
        s3 = mod_add(acc3_r, s2[11:0], denominator_value);
        // MASH 1-1-1 noise shaping: c1 + (1-z^-1)c2 + (1-z^-1)^2 c3
        corr = $signed({4'h0, s1[12]}) + $signed({4'h0, s2[12]})
             - $signed({4'h0, c2_d_r[0]}) + $signed({4'h0, s3[12]})
             - $signed({3'h0, c3_d_r, 1'b0}) + $signed({4'h0, c3_dd_r});
        // Whole value plus sign-extended correction, kept at 13 bits
        ratio_sum = {4'h0, int_value} + {{8{corr[4]}}, corr};
    end

    // Interpolator state, one step per comparator cycle
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            acc1_r    <= 12'h000;
            acc2_r    <= 12'h000;
            acc3_r    <= 12'h000;
            c2_d_r    <= 2'h0;
            c3_d_r    <= 1'b0;
            c3_dd_r   <= 1'b0;
            lfsr_r    <= 21'h000001;
            div_ratio <= 13'h0000;
        end else if (cmp_tick) begin
            acc1_r  <= s1[11:0];
            acc2_r  <= s2[11:0];
            acc3_r  <= s3[11:0];
            c2_d_r  <= {1'b0, s2[12]};
            c3_d_r  <= s3[12];
            c3_dd_r <= c3_d_r;
            // 21-bit maximal LFSR, taps 21 and 19
            lfsr_r  <= {lfsr_r[19:0], lfsr_r[20] ^ lfsr_r[18]};
            div_ratio <= ratio_sum;
        end
    end

endmodule // fndc_core

`default_nettype wire

//--- bench/fndc_host.sv
`timescale 1ns/100ps
`default_nettype none
// Host side: hands whole latched words to the core
module fndc_host (
    input  wire logic        core_clk, // Core clock
    output var  logic        wr_stb,   // Word strobe
    output var  logic [23:0] wr_word   // Latched word
);
    logic lowspur_r; // Lowest-spur mode chosen

    // Idle bus at time zero
    initial begin
        wr_stb = 1'b0;
        wr_word = 24'h000000;
        lowspur_r = 1'b0;
    end

    // One word, launched and dropped on falling edges
    task automatic write(input logic [23:0] w);
        logic [23:0] v;
        v = w;
        if (w[1:0] == 2'h3) lowspur_r = (w[10:2] == 9'h1C7);
        if (lowspur_r && w[1:0] == 2'h1 && !w[23] && w[13:2] < 12'h032)
            v[13:2] = 12'h032;
        @(negedge core_clk);
        wr_word = v;
        wr_stb = 1'b1;
        @(negedge core_clk);
        wr_stb = 1'b0;
    endtask
endmodule // fndc_host
`default_nettype wire

//--- bench/fndc_core_chk.sv
`timescale 1ns/100ps
`default_nettype none
`include "fndc_regs.vh"
// Port checks of the divider control core
module fndc_chk (
    input wire logic        core_clk,                // Clock
    input wire logic        resetn,                  // Reset
    input wire logic        wr_stb,                  // Strobe
    input wire logic [23:0] wr_word,                 // Word
    input wire logic        cmp_tick,                // Tick
    input wire logic [11:0] denominator_value,       // Denominator
    input wire logic        dither_on,               // Dither
    input wire logic [3:0]  cp_setting,              // Pump code
    input wire logic [8:0]  cp_current,              // Pump current
    input wire logic        wide_bw,                 // Wide mode
    input wire logic        monitor_output_pin_oe_n, // Pin pull
    input wire logic        monitor_output_pin_out   // Pin level
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    wire logic n_wr = wr_stb && wr_word[1:0] == `FNDC_ADDR_NDIV;
    wire logic s_wr = wr_stb && wr_word[1:0] == `FNDC_ADDR_NOISE;
    // Steps of a fast-lock episode
    sequence s_wide_start; !wide_bw ##1 wide_bw; endsequence
    sequence s_wide_end; wide_bw ##1 !wide_bw; endsequence
    property p_start; s_wide_start |-> cmp_tick || $past(cmp_tick); endproperty
    a_start: assert property (p_start) else $error("wide mode began off tick");
    property p_end; s_wide_end |-> cmp_tick || $past(cmp_tick); endproperty
    a_end: assert property (p_end) else $error("wide mode ended off tick");
    property p_rel; s_wide_end |=> monitor_output_pin_oe_n; endproperty
    a_rel: assert property (p_rel) else $error("switch kept after wide mode");
    property p_boost;
        wide_bw && $past(wide_bw) && $stable(cp_setting) |-> cp_current == {1'b0, cp_setting, 4'h0};
    endproperty
    a_boost: assert property (p_boost) else $error("pump not boosted");
    property p_oe; !monitor_output_pin_oe_n |-> $past(wide_bw); endproperty
    a_oe: assert property (p_oe) else $error("switch on outside wide mode");
    property p_pin; monitor_output_pin_out == 1'b0; endproperty
    a_pin: assert property (p_pin) else $error("switch level not ground");
    property p_den; $changed(denominator_value) |-> $past(n_wr); endproperty
    a_den: assert property (p_den) else $error("denominator moved without N word");
    property p_dith; $changed(dither_on) |-> $past(s_wr); endproperty
    a_dith: assert property (p_dith) else $error("dither moved without mode word");
    property p_tick; cmp_tick |=> !cmp_tick; endproperty
    a_tick: assert property (p_tick) else $error("tick longer than a cycle");
endmodule // fndc_chk
bind fndc_core fndc_chk i_fndc_chk (.core_clk(core_clk), .resetn(resetn), .wr_stb(wr_stb),
    .wr_word(wr_word), .cmp_tick(cmp_tick), .denominator_value(denominator_value),
    .dither_on(dither_on), .cp_setting(cp_setting), .cp_current(cp_current), .wide_bw(wide_bw),
    .monitor_output_pin_oe_n(monitor_output_pin_oe_n),
    .monitor_output_pin_out(monitor_output_pin_out));
`default_nettype wire

//--- bench/testbench.sv
`timescale 1ns/100ps
`default_nettype none
// Self-checking bench for the divider control core
module testbench;
    logic             core_clk = 1'b0;
    logic             resetn = 1'b0;
    logic             reference_input = 1'b0;
    wire logic        wr_stb, cmp_tick, dither_on, wide_bw, oe_n;
    wire logic [23:0] wr_word;
    wire logic [12:0] div_ratio;
    wire logic [11:0] num, den;
    wire logic [8:0]  int_v, cp_cur;
    wire logic [3:0]  cp_set;
    logic [12:0]      q[$];
    logic [35:0]      cpv;
    int bad_count = 0;
    int checks = 0;
    int dt[5] = '{2, 7, 9, 10, 12};
    int md[4] = '{'h1C7, 'h0F1, 'h1C7, 'h000};
    int gt[4] = '{'h0801, 'h0812, 'h0C13, 'h1002};
    int l, s, t, cp, g, n, fr, iv, pd;
    // Clock; reference at 31.25 MHz keeps the comparator legal
    always #2 core_clk = ~core_clk;
    always #16 reference_input = ~reference_input;
    fndc_host i_fndc_host (.core_clk(core_clk), .wr_stb(wr_stb), .wr_word(wr_word));
    fndc_core i_fndc_core (.core_clk(core_clk), .resetn(resetn),
        .reference_input(reference_input), .wr_stb(wr_stb), .wr_word(wr_word),
        .cmp_tick(cmp_tick), .div_ratio(div_ratio), .int_value(int_v), .numerator_value(num),
        .denominator_value(den), .dither_on(dither_on), .cp_setting(cp_set), .cp_current(cp_cur),
        .wide_bw(wide_bw), .monitor_output_pin_oe_n(oe_n), .monitor_output_pin_out());
    // Compare one result and count it
    task automatic cmp(input string w, input logic [35:0] e, input logic [35:0] v);
        checks++;
        if (v !== e) begin
            bad_count++;
            $display("Error %s expected %0h seen %0h", w, e, v);
        end
    endtask
    // Verdict and end of run
    task automatic results;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // One host word, then the edge after the one that applies it
    task automatic wr(input logic [23:0] w);
        i_fndc_host.write(w);
        @(posedge core_clk);
        #1;
    endtask
    // Next comparator pulse, bounded
    task automatic tick;
        n = 0;
        do begin
            @(posedge core_clk);
            #1;
            n++;
        end while (!cmp_tick && n < 99);
        cmp("tick", 36'h1, {35'h0, cmp_tick});
    endtask
    function automatic logic [23:0] rw(logic ld, logic [2:0] m, logic [3:0] r, logic [11:0] d);
        return {ld, m, r, 2'h0, d, 2'h1};
    endfunction
    // Main sequence
    initial begin
        void'($urandom(74));
        #12 resetn = 1'b1;
        cmp("reset", {9'h01F, 12'h002, 2'h2}, {int_v, den, oe_n, wide_bw});
        pd = 2;
        // Sum and repeat length per denominator, dither off
        foreach (dt[k]) begin
            fr = $urandom % dt[k];
            iv = 31 + $urandom % 400;
            l = (dt[k] % 6 == 0) ? 6 : (dt[k] % 2 == 0) ? 2 : (dt[k] % 3 == 0) ? 3 : 1;
            l = l * dt[k];
            wr({13'h0000, 9'h0F1, 2'h3});
            wr(rw(1'b0, 3'h0, 4'h1, dt[k][11:0]));
            cmp("den held", pd, den);
            wr({1'b0, iv[8:0], fr[11:0], 2'h0});
            cmp("active", {iv[8:0], fr[11:0], dt[k][11:0]}, {int_v, num, den});
            // Three ticks flush the delayed carries of the old setting
            tick;
            tick;
            tick;
            q = {};
            repeat (2 * l) begin
                tick;
                q.push_back(div_ratio);
            end
            s = 0;
            g = 0;
            for (int i = 0; i < l; i++) begin
                s += q[i];
                if (q[i] !== q[i + l]) g++;
            end
            cmp("repeat", 0, g);
            cmp("sum", l * iv + l * fr / dt[k], s);
            pd = dt[k];
        end
        $display("ratio test done");
        // Noise modes switch the dither
        foreach (md[k]) begin
            wr({13'h0000, md[k][8:0], 2'h3});
            cmp("dither", md[k] == 'h1C7, dither_on);
        end
        $display("dither test done");
        // Fast lock: full setup, N word alone, monitor not selected
        t = 2 + $urandom % 6;
        cp = 1 + $urandom % 15;
        for (int p = 0; p < 3; p++) begin
            if (p == 0) begin
                wr(rw(1'b1, 3'h0, 4'h1, t[11:0]));
                wr({13'h0000, 9'h0F1, 2'h3});
                wr({12'h000, 1'b0, cp[3:0], 5'h00, 2'h2});
            end
            if (p != 1) wr(rw(1'b0, (p == 0) ? 3'h6 : 3'h0, 4'h1, 12'h041));
            wr({1'b1, 9'h040, 12'h000, 2'h0});
            cmp("den", 12'h041, den);
            n = 0;
            g = 0;
            while (!wide_bw && n < 40) begin
                @(posedge core_clk);
                #1;
                n++;
            end
            while (wide_bw && g < 200) begin
                if (g == 2) cpv = {oe_n, cp_cur};
                @(posedge core_clk);
                #1;
                g++;
            end
            cmp("boost", {p == 2, cp[8:0] * 9'h010}, cpv);
            cmp("wide", t * 8, g);
            repeat (2) @(posedge core_clk);
            #1;
            cmp("after", {1'b1, cp[8:0]}, {oe_n, cp_cur});
        end
        $display("fast lock test done");
        // Comparator spacing per doubler and divide factor
        foreach (gt[k]) begin
            wr({12'h000, gt[k][4], 4'h1, 5'h00, 2'h2});
            wr(rw(1'b0, 3'h0, gt[k][3:0], 12'h041));
            tick;
            tick;
            s = $time;
            tick;
            cmp("gap", gt[k][15:8], ($time - s) / 4);
        end
        $display("rate test done");
        results;
    end
    // Hang guard, about ten times the expected run of some 2500 cycles
    initial begin
        #100000;
        bad_count++;
        results;
    end
endmodule // testbench
`default_nettype wire
